/* File: logic/encoder_pkg.sv */
// encoder_pkg: constants and state codes for the incremental encoder output model
// assumes: users import it whole; no timing beyond the system clock is implied
package encoder_pkg;
   localparam int COUNTS_PER_REV_DEFAULT = 1024; // counts per revolution, bar and window pairs
   localparam int COUNTS_PER_REV_MIN = 96;       // smallest standard resolution
   localparam int COUNTS_PER_REV_MAX = 1024;     // largest standard resolution
   localparam int STATES_PER_CYCLE = 4;        // four quarter-cycle states
   localparam int DEG_PER_CYCLE = 360;         // electrical degrees per cycle
   localparam int DEG_PER_STATE = DEG_PER_CYCLE / STATES_PER_CYCLE;
   localparam int CLK_HZ = 50_000_000;         // system clock rate
   localparam int COUNT_FREQ_MAX_KHZ = 100;    // highest guaranteed count rate
   localparam int MIN_STEP_CYCLES = CLK_HZ / (COUNT_FREQ_MAX_KHZ * 1000);
   localparam logic [1:0] ST_BOTH_LOW = 2'h0;  // {a,b} phase codes in gray order
   localparam logic [1:0] ST_A_HIGH = 2'h2;
   localparam logic [1:0] ST_BOTH_HIGH = 2'h3;
   localparam logic [1:0] ST_B_HIGH = 2'h1;
   localparam logic [1:0] PHASE_ZERO = 2'h0;
   localparam logic [1:0] PHASE_ONE = 2'h1;
   localparam logic [1:0] PHASE_TWO = 2'h2;
   localparam logic [1:0] PHASE_THREE = 2'h3;
   localparam logic [1:0] PHASE_STEP = 2'h1;   // one quarter-cycle state per step
endpackage : encoder_pkg

/* File: logic/step_sync.sv */
// step_sync: brings the shaft step pins into the clock domain and makes step pulses
// assumes: stepPin and dirPin are asynchronous; one pulse per rising edge of stepPin
`timescale 1ns/1ps
module step_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // raw pins
   input wire logic stepPin,
   input wire logic dirPin,
   // synchronous result
   output logic stepPulse,
   output logic dirCcw
);
   logic stepMeta;
   logic stepSync;
   logic stepLast;
   logic dirMeta;
   // two flops per pin, then an edge detector on the second one
   always_ff @(posedge clk_sys or posedge rst) begin // R10
      if (rst) begin
         stepMeta <= 1'b0;
         stepSync <= 1'b0;
         stepLast <= 1'b0;
         dirMeta <= 1'b0;
         dirCcw <= 1'b0;
         stepPulse <= 1'b0;
      end else begin
         stepMeta <= stepPin;
         stepSync <= stepMeta;
         stepLast <= stepSync;
         dirMeta <= dirPin;
         dirCcw <= dirMeta;
         stepPulse <= stepSync & ~stepLast;
      end
   end
endmodule : step_sync

/* File: logic/quadrature_encoder.sv */
// quadrature_encoder: shaft position model driving A, B and optional index outputs
// assumes: shaft moves by step pins, one pulse = one quarter-cycle state (90 deg e)
// assumes: the decoder samples faster than the guaranteed count rate
`timescale 1ns/1ps
// Operation
// R1: A and B square waves, 90 degrees apart
// R2: cycle is 360 degrees; revolution N cycles
// R3: each channel high for half a cycle
// R4: four 90-degree states per cycle
// R5: ccw A leads B, cw B leads
// R6: index once per revolution, three-channel only
// R7: index high one state, A and B low
// R8: counts per revolution is a parameter
// R9: index combines comparator with A and B
// R10: count rate limited; decoder samples fast enough
// R11: gray sequence, single channel changes per step
module quadrature_encoder #(
   parameter int COUNTS_PER_REVOLUTION = encoder_pkg::COUNTS_PER_REV_DEFAULT,
   parameter bit HAS_INDEX = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // shaft motion pins, asynchronous
   input wire logic stepPin,
   input wire logic dirPin,
   // encoder outputs
   output logic chanA,
   output logic chanB,
   output logic index_channel,
   // shaft position for observation
   output logic [$clog2(encoder_pkg::COUNTS_PER_REV_MAX)-1:0] cycleCount
);
   import encoder_pkg::*;
   localparam int CW = $clog2(COUNTS_PER_REV_MAX);
   localparam logic [CW-1:0] LAST_CYCLE = CW'(COUNTS_PER_REVOLUTION - 1);
   localparam logic [CW-1:0] CYCLE_ZERO = '0;

   logic stepPulse;
   logic dirCcw;
   logic [1:0] phase;          // quarter-cycle position within one cycle
   logic [1:0] next_phase;
   logic [CW-1:0] next_cycle;
   logic [1:0] grayCode;
   logic indexWindow;
   logic next_index;

   step_sync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .stepPin(stepPin),
      .dirPin(dirPin),
      .stepPulse(stepPulse),
      .dirCcw(dirCcw)
   );

   // step phase forward for ccw, back for cw; wrap the cycle count
   assign next_phase = !stepPulse ? phase :
      (dirCcw ? phase + PHASE_STEP : phase - PHASE_STEP); // R4 R5
   assign next_cycle = !stepPulse ? cycleCount :
      (dirCcw && phase == PHASE_THREE) ?
         ((cycleCount == LAST_CYCLE) ? CYCLE_ZERO : cycleCount + 1'b1) :
      (!dirCcw && phase == PHASE_ZERO) ?
         ((cycleCount == CYCLE_ZERO) ? LAST_CYCLE : cycleCount - 1'b1) : cycleCount; // R2 R8

   // phase to gray-coded {a,b}: 00,10,11,01 so a leads b when counting up
   assign grayCode = (next_phase == PHASE_ZERO) ? ST_BOTH_LOW :
                     (next_phase == PHASE_ONE) ? ST_A_HIGH :
                     (next_phase == PHASE_TWO) ? ST_BOTH_HIGH : ST_B_HIGH; // R1 R3 R11

   // index comparator: cycle zero of the revolution, gated by A and B both low
   assign indexWindow = (next_cycle == CYCLE_ZERO); // R6
   assign next_index = HAS_INDEX && indexWindow && (grayCode == ST_BOTH_LOW); // R7 R9

   // position and output registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase <= PHASE_ZERO;
         cycleCount <= CYCLE_ZERO;
         chanA <= 1'b0;
         chanB <= 1'b0;
         index_channel <= 1'b0;
      end else begin
         phase <= next_phase;
         cycleCount <= next_cycle;
         chanA <= grayCode[1];
         chanB <= grayCode[0];
         index_channel <= next_index;
      end
   end

   // assertions
   a_gray_single: assert property (@(posedge clk_sys) disable iff (rst) // R11
      !($changed(chanA) && $changed(chanB)))
      else $error("both channels changed together");
   a_ccw_a_leads: assert property (@(posedge clk_sys) disable iff (rst) // R5
      ($rose(chanA) && dirCcw) |-> !chanB)
      else $error("a rose ccw while b high");
   a_cw_b_leads: assert property (@(posedge clk_sys) disable iff (rst) // R5
      ($rose(chanB) && !dirCcw) |-> !chanA)
      else $error("b rose cw while a high");
   a_index_lows: assert property (@(posedge clk_sys) disable iff (rst) // R7
      index_channel |-> (!chanA && !chanB))
      else $error("index high outside both-low state");
   a_index_pos: assert property (@(posedge clk_sys) disable iff (rst) // R6
      index_channel |-> (cycleCount == CYCLE_ZERO && phase == PHASE_ZERO))
      else $error("index away from revolution origin");
   a_index_absent: assert property (@(posedge clk_sys) disable iff (rst) // R6
      !HAS_INDEX |-> !index_channel)
      else $error("index on two-channel variant");
   a_step_moves: assert property (@(posedge clk_sys) disable iff (rst) // R4
      stepPulse |=> ($changed(chanA) || $changed(chanB)))
      else $error("step did not change state");
   a_hold_still: assert property (@(posedge clk_sys) disable iff (rst) // R3
      !stepPulse |=> ($stable(chanA) && $stable(chanB)))
      else $error("outputs moved without a step");
   a_cycle_range: assert property (@(posedge clk_sys) disable iff (rst) // R8
      cycleCount <= LAST_CYCLE)
      else $error("cycle count beyond revolution");
   // the last cycle wraps to zero when stepping forward
   a_wrap_forward: assert property (@(posedge clk_sys) disable iff (rst) // R8
      (stepPulse && dirCcw && phase == PHASE_THREE && cycleCount == LAST_CYCLE)
      |=> (cycleCount == CYCLE_ZERO))
      else $error("cycle count did not wrap forward");
   // cycle zero wraps to the last cycle when stepping back
   a_wrap_back: assert property (@(posedge clk_sys) disable iff (rst) // R8
      (stepPulse && !dirCcw && phase == PHASE_ZERO && cycleCount == CYCLE_ZERO)
      |=> (cycleCount == LAST_CYCLE))
      else $error("cycle count did not wrap back");
   // reaching the origin raises the index on three-channel builds
   a_index_origin: assert property (@(posedge clk_sys) disable iff (rst) // R6
      (HAS_INDEX && stepPulse && dirCcw && phase == PHASE_THREE && cycleCount == LAST_CYCLE)
      |=> index_channel)
      else $error("index missing at revolution origin");
endmodule : quadrature_encoder

/* File: dv/quad_decoder_model.sv */
// quad_decoder_model: receiving decoder, counts states seen on a and b
// assumes: clk_sys is far faster than the guaranteed count rate
`timescale 1ns/1ps
module quad_decoder_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // encoder lines
   input wire logic chanA,
   input wire logic chanB,
   // decoded result
   output int position,
   output int doubleChange
);
   logic [1:0] prev;
   wire logic [1:0] cur = {chanB, chanA ^ chanB};
   wire logic [1:0] diff = cur - prev;
   // sample every clock so no state is missed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev <= 2'h0;
         position <= 0;
         doubleChange <= 0;
      end else begin
         prev <= cur;
         if (diff == 2'h1) position <= position + 1;
         if (diff == 2'h3) position <= position - 1;
         if (diff == 2'h2) doubleChange <= doubleChange + 1;
      end
   end
endmodule : quad_decoder_model

/* File: dv/quadrature_encoder_tb.sv */
// quadrature_encoder_tb: steps the shaft both ways and over a revolution
// assumes: latency of four clocks, steps held four clocks high and low
`timescale 1ns/1ps
module quadrature_encoder_tb;
   import encoder_pkg::*;
   localparam int N = COUNTS_PER_REV_MIN;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic stepPin = 1'b0;
   logic dirPin = 1'b0;
   logic chanA, chanB, index_channel, idx2;
   logic [9:0] cycleCount;
   int position, doubleChange, idxSeen;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #10 clk_sys = ~clk_sys;
   always @(posedge index_channel) idxSeen++;
   // three-channel unit under test and a two-channel twin
   quadrature_encoder #(.COUNTS_PER_REVOLUTION(N), .HAS_INDEX(1'b1)) uut (.clk_sys(clk_sys),
      .rst(rst), .stepPin(stepPin), .dirPin(dirPin), .chanA(chanA), .chanB(chanB),
      .index_channel(index_channel), .cycleCount(cycleCount));
   quadrature_encoder #(.COUNTS_PER_REVOLUTION(N), .HAS_INDEX(1'b0)) uut2 (.clk_sys(clk_sys),
      .rst(rst), .stepPin(stepPin), .dirPin(dirPin), .chanA(), .chanB(),
      .index_channel(idx2), .cycleCount());
   quad_decoder_model dec (.clk_sys(clk_sys), .rst(rst), .chanA(chanA), .chanB(chanB),
      .position(position), .doubleChange(doubleChange));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // one shaft state, direction settled three clocks ahead
   task automatic step(input logic d);
      @(posedge clk_sys) #1 dirPin = d;
      repeat (3) @(posedge clk_sys);
      #1 stepPin = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 stepPin = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic ccw_cycle();
      logic [1:0] exp [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
      for (int i = 0; i < 4; i++) begin
         step(1'b1);
         check("ab_ccw", {chanA, chanB}, exp[i]);
      end
      check("count_ccw", cycleCount, 10'h001);
   endtask : ccw_cycle
   task automatic cw_back();
      logic [1:0] exp [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++) begin
         step(1'b0);
         check("ab_cw", {chanA, chanB}, exp[i]);
         check("index_cw", index_channel, i == 3);
      end
      step(1'b0);
      check("index_width", index_channel, 1'b0);
      check("count_wrap", cycleCount, 10'(N - 1));
   endtask : cw_back
   task automatic revolution();
      step(1'b1);
      idxSeen = 0;
      repeat (4 * N) step(1'b1);
      check("index_once", idxSeen, 10'h001);
      check("count_rev", cycleCount, 10'h000);
      check("decoded", position, 10'(4 * N));
      check("gray", doubleChange, 10'h000);
      check("two_channel", idx2, 1'b0);
   endtask : revolution
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 rst = 1'b0;
      check("reset", {chanA, chanB, index_channel}, 3'h0);
      ccw_cycle();
      cw_back();
      revolution();
      conclude();
   end
endmodule : quadrature_encoder_tb
